// File: src/scc_pkg.sv
// constants for the system clock source selector and divider
// assumes one 10 MHz system clock and an AHB-Lite register port
// Operation
// RULE_01: runs from the fast internal oscillator during and after reset
// RULE_02: software enables and settles the main oscillator before selecting it
// RULE_03: internal oscillator divided by four is a selectable source
// RULE_04: with bypass set, source field picks main, internal, internal/4, slow
// RULE_05: only main oscillator feeds the PLL; PLL used when bypass clear, source zero
// RULE_06: software uses the PLL only with a 3.579545 to 8.192 MHz reference
// RULE_07: without PLL, software may pick any crystal from 1 to 8.192 MHz
// RULE_08: override bit makes extended register fields replace base fields
// RULE_09: in deep sleep, source and divisor come from deep-sleep configuration
// RULE_10: divisor divides PLL output or selected oscillator per bypass
// RULE_11: applied divisor is the field encoding plus one
// RULE_12: PLL output is halved before the divisor is applied
// RULE_13: encodings 0 to 2 reserved with PLL; bypassed 0 gives /2; default 0xF
// RULE_14: peripheral clocks come from system clock, each with its own enable
// RULE_15: slow internal oscillator selectable so the main oscillator may stop
// RULE_16: crystal change or PLL power-up loads relock counter 0x1200, PLL held off
// RULE_17: rewriting the same crystal value does not start a relock
// RULE_18: PLL enabled and selected together keeps oscillator until relock ends
// RULE_19: every source or divisor switch is glitch free; a forced switch off an unlocked PLL drives the output low at once, mid period
package scc_pkg;
   localparam logic [11:0] OFS_RUN  = 12'h000;
   localparam logic [11:0] OFS_EXT  = 12'h004;
   localparam logic [11:0] OFS_DSLP = 12'h008;
   localparam logic [11:0] OFS_PCLK = 12'h00C;
   localparam logic [11:0] OFS_STAT = 12'h010;

   localparam int MAIN_OSC_DIS_BIT = 0;
   localparam int SRC_LSB      = 4;
   localparam int CRYSTAL_VALUE_SEL_LSB     = 6;
   localparam int BYPASS_BIT   = 11;
   localparam int PWRDN_BIT    = 13;
   localparam int DIV_LSB      = 23;
   localparam int OVR_BIT      = 31;

   localparam int ST_DIV_LSB   = 0;
   localparam int ST_SRC_LSB   = 8;
   localparam int ST_PLL_BIT   = 12;
   localparam int ST_LOCK_BIT  = 15;
   localparam int ST_CNT_LSB   = 16;

   localparam logic [31:0] RUN_RST   = 32'h07802AD0;
   localparam logic [31:0] RUN_MASK  = 32'h07802FF1;
   localparam logic [31:0] EXT_RST   = 32'h07802810;
   localparam logic [31:0] EXT_MASK  = 32'h9F802830;
   localparam logic [31:0] DSLP_RST  = 32'h07800010;
   localparam logic [31:0] DSLP_MASK = 32'h1F800030;
   localparam logic [7:0]  PCLK_RST  = 8'h00;

   localparam logic [1:0]  SRC_MAIN  = 2'h0;
   localparam logic [1:0]  SRC_INTERNAL_OSC_FAST  = 2'h1;
   localparam logic [1:0]  SRC_IOSC4 = 2'h2;
   localparam logic [1:0]  SRC_SLOW  = 2'h3;

   localparam logic [15:0] RELOCK_COUNT = 16'h1200;
   localparam logic [1:0]  INTERNAL_OSC_FAST_QUART   = 2'h3;
   localparam logic [6:0]  DIV_MIN      = 7'h02;
   localparam logic [6:0]  RST_DIV_N    = 7'h10;
endpackage

// File: src/scc_osc_sync.sv
// one oscillator input brought into the system clock as a rising-edge tick
// assumes the oscillator is slower than half the system clock
`timescale 1ns/100ps
module scc_osc_sync (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic osc_in,
   output logic      tick
);
   logic s1_r;
   logic s2_r;
   logic s3_r;
   logic level_r;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s1_r    <= 1'b0;
         s2_r    <= 1'b0;
         s3_r    <= 1'b0;
         level_r <= 1'b0;
      end else begin
         s1_r <= osc_in;
         s2_r <= s1_r;
         s3_r <= s2_r;
         if (s2_r == s3_r) begin
            level_r <= s3_r;
         end
      end
   end

   // s1 is left to settle; a new level counts once the later pair agree
   assign tick = (s2_r == s3_r) && s3_r && !level_r;
endmodule

// File: src/scc_clock_source_divider.sv
// system clock source selection, PLL relock gating and output divider
// assumes oscillator inputs are raw clocks slower than half of CLK_SYS
`timescale 1ns/100ps
module scc_clock_source_divider #(
   parameter logic [15:0] RELOCK_LOAD = scc_pkg::RELOCK_COUNT
) (
   input  wire logic        CLK_SYS,
   input  wire logic        SYS_RST,
   input  wire logic        HSEL,
   input  wire logic [31:0] HADDR,
   input  wire logic [1:0]  HTRANS,
   input  wire logic        HWRITE,
   input  wire logic [2:0]  HSIZE,
   input  wire logic [31:0] HWDATA,
   input  wire logic        HREADY,
   output logic      [31:0] HRDATA,
   output logic             HREADYOUT,
   output logic             HRESP,
   input  wire logic        MAIN_OSC_IN,
   input  wire logic        INTERNAL_OSC_FAST_IN,
   input  wire logic        SLOW_OSC_IN,
   input  wire logic        PLL_VCO_IN,
   input  wire logic        DEEP_SLEEP,
   output logic             CORE_CLOCK_OUT,
   output logic             CORE_CLK_TICK,
   output logic      [7:0]  PERIPH_CLK_TICK,
   output logic             PLL_PWRDN,
   output logic             MAIN_OSC_PWRDN,
   output logic             PLL_LOCKED
);
   logic [31:0] run_clock_config_r;
   logic [31:0] run_clock_config_ext_r;
   logic [31:0] deep_sleep_clock_config_r;
   logic [7:0]  pclk_en_r;
   logic        wr_pend_r;
   logic [11:0] addr_r;
   logic [31:0] hrdata_r;
   logic [31:0] rd_val;
   logic        t_main;
   logic        t_internal_osc_fast;
   logic        t_slow;
   logic        t_vco;
   logic [1:0]  q4_r;
   logic        t_iosc4;
   logic        vco_ph_r;
   logic        t_pll;
   logic        ext_config_override;
   logic        eff_bypass;
   logic [1:0]  osc_source_sel;
   logic [5:0]  core_clock_out_divisor;
   logic        eff_pwrdn;
   logic        pwrdn_q_r;
   logic        pll_pwrup;
   logic        crystal_value_sel_chg;
   logic        crystal_value_sel_same_wr;
   logic        relock_trig;
   logic [15:0] relock_cnt_r;
   logic        pll_ready;
   logic        want_pll;
   logic [6:0]  div_n;
   logic        cur_pll_r;
   logic [1:0]  cur_src_r;
   logic [6:0]  cur_div_r;
   logic [6:0]  cnt_r;
   logic        src_tick;
   logic        wrap;
   logic        force_sw;
   logic [6:0]  cnt_nxt;
   logic [6:0]  div_nxt;
   logic        out_r;
   logic        tick_r;
   logic [7:0]  pclk_tick_r;
   logic        locked_r;
   logic        main_osc_off_r;
   logic        wrote_r;
   logic        ready_r;

   scc_osc_sync u_main (.clk(CLK_SYS), .rst(SYS_RST), .osc_in(MAIN_OSC_IN), .tick(t_main));
   scc_osc_sync u_internal_osc_fast (.clk(CLK_SYS), .rst(SYS_RST), .osc_in(INTERNAL_OSC_FAST_IN), .tick(t_internal_osc_fast));
   scc_osc_sync u_slow (.clk(CLK_SYS), .rst(SYS_RST), .osc_in(SLOW_OSC_IN), .tick(t_slow));
   scc_osc_sync u_vco  (.clk(CLK_SYS), .rst(SYS_RST), .osc_in(PLL_VCO_IN), .tick(t_vco));

   // bus slave: zero wait states, read data fetched in the address phase
   // ready is a flop, so it only rises at the first edge after reset
   always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
      if (SYS_RST) begin
         wr_pend_r <= 1'b0;
         addr_r    <= 12'h000;
         hrdata_r  <= 32'h00000000;
         ready_r   <= 1'b0;
      end else if (HSEL && HREADY && HTRANS[1]) begin
         wr_pend_r <= HWRITE;
         addr_r    <= HADDR[11:0];
         hrdata_r  <= HWRITE ? 32'h00000000 : rd_val;
         ready_r   <= 1'b1;
      end else begin
         wr_pend_r <= 1'b0;
         ready_r   <= 1'b1;
      end
   end

   always_comb begin
      rd_val = 32'h00000000;
      unique case (HADDR[11:0])
         scc_pkg::OFS_RUN:  rd_val = run_clock_config_r;
         scc_pkg::OFS_EXT:  rd_val = run_clock_config_ext_r;
         scc_pkg::OFS_DSLP: rd_val = deep_sleep_clock_config_r;
         scc_pkg::OFS_PCLK: rd_val = {24'h000000, pclk_en_r};
         scc_pkg::OFS_STAT: begin
            rd_val[scc_pkg::ST_DIV_LSB +: 7]  = cur_div_r;
            rd_val[scc_pkg::ST_SRC_LSB +: 2]  = cur_src_r;
            rd_val[scc_pkg::ST_PLL_BIT]       = cur_pll_r;
            rd_val[scc_pkg::ST_LOCK_BIT]      = pll_ready;
            rd_val[scc_pkg::ST_CNT_LSB +: 16] = relock_cnt_r;
         end
         default: rd_val = 32'h00000000;
      endcase
   end

   always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
      if (SYS_RST) begin
         run_clock_config_r        <= scc_pkg::RUN_RST;
         run_clock_config_ext_r    <= scc_pkg::EXT_RST;
         deep_sleep_clock_config_r <= scc_pkg::DSLP_RST;
         pclk_en_r                 <= scc_pkg::PCLK_RST;
      end else if (wr_pend_r) begin
         unique case (addr_r)
            scc_pkg::OFS_RUN:  run_clock_config_r <= HWDATA & scc_pkg::RUN_MASK;
            scc_pkg::OFS_EXT:  run_clock_config_ext_r <= HWDATA & scc_pkg::EXT_MASK;
            scc_pkg::OFS_DSLP: deep_sleep_clock_config_r <= HWDATA & scc_pkg::DSLP_MASK;
            scc_pkg::OFS_PCLK: pclk_en_r <= HWDATA[7:0];
            default: ;
         endcase
      end
   end

   // derived sources: internal/4 and halved VCO
   always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
      if (SYS_RST) begin
         q4_r     <= 2'h0;
         vco_ph_r <= 1'b0;
      end else begin
         if (t_internal_osc_fast) begin
            q4_r <= q4_r + 2'h1;
         end
         if (t_vco) begin
            vco_ph_r <= ~vco_ph_r;
         end
      end
   end
   assign t_iosc4 = t_internal_osc_fast && (q4_r == scc_pkg::INTERNAL_OSC_FAST_QUART); // see RULE_03
   assign t_pll   = t_vco && vco_ph_r;                       // see RULE_12

   // effective fields: deep sleep first, then the extended override
   assign ext_config_override = run_clock_config_ext_r[scc_pkg::OVR_BIT];
   always_comb begin
      if (DEEP_SLEEP) begin // see RULE_09
         eff_bypass     = 1'b1;
         osc_source_sel = deep_sleep_clock_config_r[scc_pkg::SRC_LSB +: 2];
         core_clock_out_divisor = deep_sleep_clock_config_r[scc_pkg::DIV_LSB +: 6];
      end else if (ext_config_override) begin // see RULE_08
         eff_bypass     = run_clock_config_ext_r[scc_pkg::BYPASS_BIT];
         osc_source_sel = run_clock_config_ext_r[scc_pkg::SRC_LSB +: 2];
         core_clock_out_divisor = run_clock_config_ext_r[scc_pkg::DIV_LSB +: 6];
      end else begin
         eff_bypass     = run_clock_config_r[scc_pkg::BYPASS_BIT];
         osc_source_sel = run_clock_config_r[scc_pkg::SRC_LSB +: 2];
         core_clock_out_divisor = {2'h0, run_clock_config_r[scc_pkg::DIV_LSB +: 4]};
      end
   end
   assign eff_pwrdn = ext_config_override ? run_clock_config_ext_r[scc_pkg::PWRDN_BIT]
                                          : run_clock_config_r[scc_pkg::PWRDN_BIT];

   // relock counter runs on main oscillator ticks
   assign crystal_value_sel_same_wr = wr_pend_r && (addr_r == scc_pkg::OFS_RUN) &&
      (HWDATA[scc_pkg::CRYSTAL_VALUE_SEL_LSB +: 5] == run_clock_config_r[scc_pkg::CRYSTAL_VALUE_SEL_LSB +: 5]);
   assign crystal_value_sel_chg    = wr_pend_r && (addr_r == scc_pkg::OFS_RUN) && !crystal_value_sel_same_wr; // see RULE_17
   assign pll_pwrup   = pwrdn_q_r && !eff_pwrdn;
   assign relock_trig = crystal_value_sel_chg || pll_pwrup; // see RULE_16

   always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
      if (SYS_RST) begin
         pwrdn_q_r    <= 1'b1;
         relock_cnt_r <= 16'h0000;
      end else begin
         pwrdn_q_r <= eff_pwrdn;
         if (relock_trig) begin
            relock_cnt_r <= RELOCK_LOAD; // see RULE_16
         end else if (t_main && (relock_cnt_r != 16'h0000)) begin
            relock_cnt_r <= relock_cnt_r - 16'h0001;
         end
      end
   end
   assign pll_ready = !eff_pwrdn && (relock_cnt_r == 16'h0000) && !relock_trig;

   // only the main oscillator references the PLL
   assign want_pll = !eff_bypass && (osc_source_sel == scc_pkg::SRC_MAIN) && pll_ready; // see RULE_05
   // bypassed encoding 0 still gives /2; reserved PLL codes are not trapped
   assign div_n = (core_clock_out_divisor == 6'h00) ? scc_pkg::DIV_MIN // see RULE_13
                                            : {1'b0, core_clock_out_divisor} + 7'h01; // see RULE_11

   always_comb begin
      src_tick = t_main;
      if (cur_pll_r) begin
         src_tick = t_pll; // see RULE_10
      end else begin
         unique case (cur_src_r) // see RULE_04
            scc_pkg::SRC_MAIN:  src_tick = t_main;
            scc_pkg::SRC_INTERNAL_OSC_FAST:  src_tick = t_internal_osc_fast;
            scc_pkg::SRC_IOSC4: src_tick = t_iosc4;
            scc_pkg::SRC_SLOW:  src_tick = t_slow; // see RULE_15
         endcase
      end
   end

   // new settings are taken at the end of a whole output period, or at once when force_sw is set
   assign wrap     = src_tick && (cnt_r == cur_div_r - 7'h01); // see RULE_19
   // an unlocked PLL gives no trustworthy edges, so the switch is immediate
   assign force_sw = cur_pll_r && !pll_ready; // see RULE_18

   always_comb begin
      cnt_nxt = cnt_r;
      div_nxt = cur_div_r;
      if (force_sw || wrap) begin
         cnt_nxt = 7'h00;
         div_nxt = div_n;
      end else if (src_tick) begin
         cnt_nxt = cnt_r + 7'h01;
      end
   end

   always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
      if (SYS_RST) begin
         cur_pll_r <= 1'b0;
         cur_src_r <= scc_pkg::SRC_INTERNAL_OSC_FAST; // see RULE_01
         cur_div_r <= scc_pkg::RST_DIV_N;
         cnt_r     <= 7'h00;
      end else begin
         cnt_r     <= cnt_nxt;
         cur_div_r <= div_nxt;
         if (force_sw || wrap) begin
            cur_pll_r <= want_pll; // see RULE_18
            cur_src_r <= osc_source_sel;
         end
      end
   end

   // output high for the first half of each period
   always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
      if (SYS_RST) begin
         out_r       <= 1'b0;
         tick_r      <= 1'b0;
         pclk_tick_r <= 8'h00;
      end else begin
         out_r       <= !force_sw && (cnt_nxt < (div_nxt >> 1));
         tick_r      <= wrap && !force_sw;
         pclk_tick_r <= pclk_en_r & {8{wrap && !force_sw}}; // see RULE_14
      end
   end

   always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
      if (SYS_RST) begin
         locked_r   <= 1'b0;
         main_osc_off_r <= 1'b0;
         wrote_r    <= 1'b0;
      end else begin
         locked_r   <= pll_ready;
         main_osc_off_r <= run_clock_config_r[scc_pkg::MAIN_OSC_DIS_BIT];
         if ((wr_pend_r && addr_r != scc_pkg::OFS_PCLK) || DEEP_SLEEP) begin
            wrote_r <= 1'b1;
         end
      end
   end

   assign HRDATA          = hrdata_r;
   assign HREADYOUT       = ready_r;
   assign HRESP           = 1'b0;
   assign CORE_CLOCK_OUT  = out_r;
   assign CORE_CLK_TICK   = tick_r;
   assign PERIPH_CLK_TICK = pclk_tick_r;
   assign PLL_PWRDN       = pwrdn_q_r;
   assign MAIN_OSC_PWRDN  = main_osc_off_r;
   assign PLL_LOCKED      = locked_r;

   sequence relock_start_s;
      relock_trig;
   endsequence
   sequence relock_loaded_s;
      relock_cnt_r == RELOCK_LOAD;
   endsequence

   internal_osc_fast_reset_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // see RULE_01
      !wrote_r |-> (cur_src_r == scc_pkg::SRC_INTERNAL_OSC_FAST && !cur_pll_r))
      else $error("left internal oscillator without software change");
   quarter_tick_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // see RULE_03
      t_iosc4 |-> ##1 (q4_r == 2'h0))
      else $error("internal quarter tick off phase");
   pll_ref_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // see RULE_05
      cur_pll_r |-> $past(cur_pll_r) || $past(want_pll))
      else $error("pll taken without main oscillator select");
   override_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // see RULE_08
      (ext_config_override && !DEEP_SLEEP && wrap &&
         run_clock_config_ext_r[scc_pkg::DIV_LSB +: 6] != 6'h00) |=>
         cur_div_r == {1'b0, $past(run_clock_config_ext_r[scc_pkg::DIV_LSB +: 6])} + 7'h01)
      else $error("override ignored");
   deep_src_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // see RULE_09
      DEEP_SLEEP |-> (eff_bypass &&
         osc_source_sel == deep_sleep_clock_config_r[scc_pkg::SRC_LSB +: 2]))
      else $error("deep sleep source not used");
   div_adopt_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // see RULE_11
      (wrap && core_clock_out_divisor == 6'h0F) |=> cur_div_r == 7'h10)
      else $error("divisor not encoding plus one");
   relock_load_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // see RULE_16
      relock_start_s |=> relock_loaded_s ##1 !cur_pll_r)
      else $error("relock not started");
   same_crystal_value_sel_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // see RULE_17
      (crystal_value_sel_same_wr && !pll_pwrup && relock_cnt_r == 16'h0000) |=> relock_cnt_r == 16'h0000)
      else $error("same crystal value caused relock");
   glitch_free_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // see RULE_19
      $changed(cur_div_r) |-> $past(wrap || force_sw))
      else $error("divisor changed mid period");
   periph_tick_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // see RULE_14
      (PERIPH_CLK_TICK != 8'h00) |-> CORE_CLK_TICK)
      else $error("peripheral tick without core tick");
endmodule

// File: sim/scc_clock_source_divider_tb.sv
// self-checking bench for the clock source selector and divider
// assumes the design alone on the bus; oscillators are made here from one cycle counter
`timescale 1ns/100ps
module scc_clock_source_divider_tb;
   logic        clk_sys    = 1'b0;
   logic        sys_rst    = 1'b1;
   logic        hsel       = 1'b0;
   logic [31:0] haddr      = 32'h00000000;
   logic [1:0]  htrans     = 2'h0;
   logic        hwrite     = 1'b0;
   logic [31:0] hwdata     = 32'h00000000;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        deep_sleep = 1'b0;
   logic        core_tick;
   logic [7:0]  periph;
   logic        pll_pwrdn;
   logic        main_osc_pwrdn;
   logic        pll_locked;
   logic        core_clk;
   logic        hresp;
   logic [7:0]  cyc        = 8'h00;
   logic [31:0] seed       = 32'h00000005;
   int          n_fail     = 0;
   int          comparisons = 0;
   int          tcnt       = 0;
   logic [11:0] ofs [5]    = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h010};
   logic [31:0] rv  [5]    = '{32'h07802AD0, 32'h07802810, 32'h07800010, 32'h0, 32'h00000110};
   // relock shortened to 16 main ticks to keep the run short
   scc_clock_source_divider #(.RELOCK_LOAD(16'h0010)) u_dut (
      .CLK_SYS         (clk_sys),
      .SYS_RST         (sys_rst),
      .HSEL            (hsel),
      .HADDR           (haddr),
      .HTRANS          (htrans),
      .HWRITE          (hwrite),
      .HSIZE           (3'h2),
      .HWDATA          (hwdata),
      .HREADY          (hreadyout),
      .HRDATA          (hrdata),
      .HREADYOUT       (hreadyout),
      .HRESP           (hresp),
      .MAIN_OSC_IN     (cyc[3]),
      .INTERNAL_OSC_FAST_IN         (cyc[2]),
      .SLOW_OSC_IN     (cyc[5]),
      .PLL_VCO_IN      (cyc[1]),
      .DEEP_SLEEP      (deep_sleep),
      .CORE_CLOCK_OUT  (core_clk),
      .CORE_CLK_TICK   (core_tick),
      .PERIPH_CLK_TICK (periph),
      .PLL_PWRDN       (pll_pwrdn),
      .MAIN_OSC_PWRDN  (main_osc_pwrdn),
      .PLL_LOCKED      (pll_locked)
   );
   initial forever #50 clk_sys = ~clk_sys;
   // oscillators: main 16, internal 8, slow 64, vco 4 cycles per period
   always @(posedge clk_sys) begin
      cyc <= cyc + 8'h01;
      tcnt <= tcnt + 1;
      if (tcnt == 40000) begin
         n_fail = n_fail + 1;
         results();
      end
   end
   task automatic results();
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         n_fail++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      @(posedge clk_sys);
      hsel <= 1'b1;
      haddr <= {20'h00000, a};
      htrans <= 2'h2;
      hwrite <= wr;
      @(posedge clk_sys);
      while (hreadyout !== 1'b1) @(posedge clk_sys);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge clk_sys);
      while (hreadyout !== 1'b1) @(posedge clk_sys);
      q = hrdata;
      chk("response", 32'h0, {31'h0, hresp});
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [11:0] a, output logic [31:0] q);
      bus(1'b0, a, 32'h00000000, q);
   endtask
   task automatic wait_tick();
      @(negedge clk_sys);
      while (core_tick !== 1'b1) @(negedge clk_sys);
   endtask
   // the first new period may start off phase, so three ticks are skipped
   task automatic measure(output int p);
      repeat (3) wait_tick();
      p = 0;
      do begin
         @(negedge clk_sys);
         p++;
      end while (core_tick !== 1'b1);
      chk("clock out at period start", 32'h1, {31'h0, core_clk});
   endtask
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic int expp(input logic [1:0] s, input logic [5:0] e, input logic pll);
      int b;
      b = pll ? 8 : (s == 2'h0 ? 16 : s == 2'h1 ? 8 : s == 2'h2 ? 32 : 64);
      return b * (e == 6'h00 ? 2 : int'(e) + 1);
   endfunction
   initial begin
      logic [31:0] q;
      logic [31:0] v;
      logic [5:0]  e;
      logic [7:0]  en;
      int          p;
      repeat (12) @(posedge clk_sys);
      @(negedge clk_sys);
      chk("ready in reset", 32'h0, {31'h0, hreadyout});
      chk("pll pwrdn in reset", 32'h1, {31'h0, pll_pwrdn});
      @(posedge clk_sys);
      sys_rst <= 1'b0;
      for (int i = 0; i < 5; i++) begin
         rd(ofs[i], q);
         chk("reset value", rv[i], q);
      end
      measure(p);
      chk("reset period", 32'd128, p);
      wr(12'h020, 32'hFFFFFFFF);
      rd(12'h020, q);
      chk("unmapped", 32'h0, q);
      for (int s = 0; s < 4; s++) begin
         v = rnd();
         e = (s == 0) ? 6'h00 : {2'h0, v[3:0]};
         v = 32'h00002AC0 | {31'h0, s == 1} | (32'(s) << 4) | ({26'h0, e} << 23);
         wr(scc_pkg::OFS_RUN, v);
         measure(p);
         chk("bypass period", expp(2'(s), e, 1'b0), p);
         chk("main osc pwrdn", {31'h0, s == 1}, {31'h0, main_osc_pwrdn});
      end
      wr(scc_pkg::OFS_RUN, 32'h00802AD0);
      en = 8'(rnd());
      wr(scc_pkg::OFS_PCLK, {24'h0, en});
      repeat (2) wait_tick();
      repeat (300) begin
         @(negedge clk_sys);
         chk("periph ticks", {24'h0, en & {8{core_tick}}}, {24'h0, periph});
      end
      v = rnd();
      e = {1'b0, v[4:0]};
      wr(scc_pkg::OFS_EXT, 32'h80002820 | {3'h0, e, 23'h0});
      measure(p);
      chk("override period", expp(2'h2, e, 1'b0), p);
      wr(scc_pkg::OFS_EXT, scc_pkg::EXT_RST);
      wr(scc_pkg::OFS_DSLP, 32'h01800010);
      deep_sleep <= 1'b1;
      measure(p);
      chk("deep sleep period", expp(2'h1, 6'h03, 1'b0), p);
      deep_sleep <= 1'b0;
      wr(scc_pkg::OFS_RUN, 32'h020002C0);
      repeat (4) @(negedge clk_sys);
      chk("relocking", 32'h0, {31'h0, pll_locked});
      rd(scc_pkg::OFS_STAT, q);
      chk("on pll early", 32'h0, {31'h0, q[12]});
      repeat (180) @(negedge clk_sys);
      chk("relock not short", 32'h0, {31'h0, pll_locked});
      p = 0;
      while (pll_locked !== 1'b1) begin
         @(negedge clk_sys);
         p++;
      end
      chk("relock bounded", 32'h1, {31'h0, p < 120});
      measure(p);
      chk("pll period", expp(2'h0, 6'h04, 1'b1), p);
      rd(scc_pkg::OFS_STAT, q);
      chk("on pll", 32'h1, {31'h0, q[12]});
      wr(scc_pkg::OFS_RUN, 32'h020002C0);
      repeat (20) @(negedge clk_sys);
      chk("same crystal", 32'h1, {31'h0, pll_locked});
      wr(scc_pkg::OFS_RUN, 32'h02000300);
      repeat (4) @(negedge clk_sys);
      chk("crystal change", 32'h0, {31'h0, pll_locked});
      results();
   end
endmodule
